/* File: hdl/stsf_flags.sv */
// Supply and thermal sticky status flags with read and word clear
`timescale 1ns/1ps
`include "stsf_defines.svh"

// How it works
// - Power-on flag bit 15 is set by power-on reset, kept until cleared.
// - Soft reset clears everything including power-on flag; power-on sets it.
// - Reserved supply bits 14:13 and thermal bits 15:4 read zero.
// - Frame with clear bit set wipes the whole addressed word; data ignored.
// - Frame with clear bit low only reads; word unchanged.
// - Bit 12 set on charge pump overtemperature.
// - Bit 11 set on fail-safe entry after fourth consecutive regulator undervoltage.
// - Bit 10 on switch supply undervoltage, bit 9 on its overvoltage.
// - Bit 8 on internal supply undervoltage, bit 7 on overvoltage.
// - Battery under/overvoltage bits 6 and 5 only while regulator enabled.
// - Bit 4 set on charge pump undervoltage.
// - Bit 3 set on regulator output short to ground.
// - Bit 2 on regulator undervoltage reset, bit 1 on regulator overvoltage.
// - Bit 0 is the fixed-threshold regulator undervoltage prewarning.
// - Internal undervoltage off in stop mode unless peak load or prewarning.
// - Regulator off in sleep: short and overvoltage never set; undervoltage only after the 2 ms short time.
// - Undervoltage update gated by mode; after 2 ms short it always updates.
// - Thermal bit 3 after more than 16 severe shutdowns; next wait 64 s.
// - Thermal bit 2 on severe shutdown, requesting fail-safe entry.
// - Thermal bit 1 on first-level shutdown; affected module disabled.
// - Thermal bit 0 on thermal prewarning.
// - Thermal flags stay set after the condition goes, until cleared.
module stsf_flags #(
   parameter int SC_UV_CYC = `STSF_SC_UV_US * `STSF_CLK_MHZ
) (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               soft_reset,
   input  wire stsf_pkg::stsf_req_s req,
   input  wire stsf_pkg::stsf_ctx_s ctx,
   input  wire stsf_pkg::stsf_det_s det,
   output stsf_pkg::stsf_rsp_s     rsp_r,
   output logic                    failsafe_req_r,
   output logic                    module_off_r,
   output logic                    long_wait_r
);

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   localparam int SC_W = $clog2(SC_UV_CYC + 2);

   initial begin
      if (SC_UV_CYC < 1) $error("stsf_flags: SC_UV_CYC must be positive");
   end

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic logic addr_is(input logic [6:0] a, input logic [6:0] t);
      addr_is = (a == t);
   endfunction

   logic sup_sel;
   logic thm_sel;
   logic sup_clr;
   logic thm_clr;

   assign sup_sel = req.valid && addr_is(req.addr, `STSF_SUP_ADDR);
   assign thm_sel = req.valid && addr_is(req.addr, `STSF_THM_ADDR);
   assign sup_clr = sup_sel && req.clear;
   assign thm_clr = thm_sel && req.clear;

   // ----------------------------------------
   // Detector synchronisation
   // ----------------------------------------
   stsf_pkg::stsf_det_s det_q;
   stsf_pkg::stsf_det_s det_d;
   stsf_pkg::stsf_det_s det_rise;

   stsf_sync #(
      .W ($bits(stsf_pkg::stsf_det_s))
   ) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .d       (det),
      .q       (det_q)
   );

   // Delayed copy for edge detection
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         det_d <= '0;
      end else begin
         det_d <= det_q;
      end
   end

   assign det_rise = det_q & ~det_d;

   // ----------------------------------------
   // Event counters and short timer
   // ----------------------------------------
   logic uv_fs_hit;
   logic safe_hit;
   logic sc_long;

   // Consecutive count restarts only on soft reset or when the host clears the word
   stsf_sat_cnt #(
      .W   (3),
      .MAX (`STSF_UV_FS_CNT)
   ) u_uv_cnt (
      .clk     (clk),
      .reset_n (reset_n),
      .clr     (soft_reset || sup_clr),
      .inc     (det_rise.reg_uv),
      .hit     (uv_fs_hit)
   );

   // More than the limit, hence one past it
   stsf_sat_cnt #(
      .W   (5),
      .MAX (`STSF_SEVERE_SHUTDOWN_FLAG_CNT + 1)
   ) u_tsd_cnt (
      .clk     (clk),
      .reset_n (reset_n),
      .clr     (soft_reset || thm_clr),
      .inc     (det_rise.severe_shutdown_flag),
      .hit     (safe_hit)
   );

   // Undervoltage lasting beyond the short time
   stsf_sat_cnt #(
      .W   (SC_W),
      .MAX (SC_UV_CYC + 1)
   ) u_sc_tmr (
      .clk     (clk),
      .reset_n (reset_n),
      .clr     (!det_q.reg_uv),
      .inc     (det_q.reg_uv),
      .hit     (sc_long)
   );

   // Terminal counts act once; a held count must not defeat a word clear
   logic uv_fs_d;
   logic safe_d;
   logic uv_fs_new;
   logic safe_new;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         uv_fs_d <= 1'b0;
         safe_d  <= 1'b0;
      end else begin
         uv_fs_d <= uv_fs_hit;
         safe_d  <= safe_hit;
      end
   end

   assign uv_fs_new = uv_fs_hit && !uv_fs_d;
   assign safe_new  = safe_hit && !safe_d;

   // ----------------------------------------
   // Mode gating
   // ----------------------------------------
   logic        reg_mon;
   logic        uv_upd;
   logic        int_uv_en;
   logic [15:0] sup_r;

   // Sleep with regulator off: no regulator short or overvoltage faults; undervoltage only after the short time
   assign reg_mon = !(ctx.mode == stsf_pkg::STSF_SLEEP && !ctx.reg_on);

   assign uv_upd = sc_long ||
                   (reg_mon && ctx.mode != stsf_pkg::STSF_RESTART &&
                    (ctx.mode != stsf_pkg::STSF_INIT || ctx.rst_released));

   // Stop mode saves current unless load or prewarning demands it
   assign int_uv_en = ctx.mode != stsf_pkg::STSF_STOP ||
                      det_q.load_peak || sup_r[`STSF_B_REG_PW];

   // ----------------------------------------
   // Set vectors
   // ----------------------------------------
   logic [15:0] thm_r;
   logic [15:0] sup_set;
   logic [15:0] thm_set;

   always_comb begin
      sup_set                   = '0;
      sup_set[`STSF_B_PUMP_OT]  = det_q.pump_ot;
      sup_set[`STSF_B_UV_FS]    = uv_fs_new;
      sup_set[`STSF_B_SW_UV]    = det_q.sw_uv;
      sup_set[`STSF_B_SW_OV]    = det_q.sw_ov;
      sup_set[`STSF_B_INT_UV]   = det_q.int_uv && int_uv_en;
      sup_set[`STSF_B_INT_OV]   = det_q.int_ov;
      sup_set[`STSF_B_BAT_UV]   = det_q.bat_uv && ctx.reg_on;
      sup_set[`STSF_B_BAT_OV]   = det_q.bat_ov && ctx.reg_on;
      sup_set[`STSF_B_PUMP_UV]  = det_q.pump_uv;
      sup_set[`STSF_B_REG_SC]   = det_q.reg_short && reg_mon;
      sup_set[`STSF_B_REG_UV]   = det_q.reg_uv && uv_upd;
      sup_set[`STSF_B_REG_OV]   = det_q.reg_ov && reg_mon;
      sup_set[`STSF_B_REG_PW]   = det_q.reg_prewarn;
   end

   always_comb begin
      thm_set                = '0;
      thm_set[`STSF_B_SAFE]  = safe_new;
      thm_set[`STSF_B_SEVERE_SHUTDOWN_FLAG]  = det_q.severe_shutdown_flag;
      thm_set[`STSF_B_MODULE_SHUTDOWN_FLAG]  = det_q.module_shutdown_flag;
      thm_set[`STSF_B_TPW]   = det_q.thermal_prewarn_flag;
   end

   // ----------------------------------------
   // Supply word
   // ----------------------------------------
   // Event set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sup_r <= `STSF_POR_RST;
      end else if (soft_reset) begin
         sup_r <= `STSF_SOFT_RST;
      end else if (sup_clr) begin
         sup_r <= sup_set & `STSF_SUP_MASK;
      end else begin
         sup_r <= (sup_r | sup_set) & `STSF_SUP_MASK;
      end
   end

   // ----------------------------------------
   // Thermal word
   // ----------------------------------------
   // Flags persist after the temperature drops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         thm_r <= `STSF_THM_RST;
      end else if (soft_reset) begin
         thm_r <= `STSF_THM_RST;
      end else if (thm_clr) begin
         thm_r <= thm_set & `STSF_THM_MASK;
      end else begin
         thm_r <= (thm_r | thm_set) & `STSF_THM_MASK;
      end
   end

   // ----------------------------------------
   // Protection outputs
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         failsafe_req_r <= 1'b0;
         module_off_r   <= 1'b0;
      end else begin
         failsafe_req_r <= det_rise.severe_shutdown_flag || uv_fs_new;
         module_off_r   <= det_q.module_shutdown_flag;
      end
   end

   // Long wait selection follows the safe state flag
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         long_wait_r <= 1'b0;
      end else if (soft_reset) begin
         long_wait_r <= 1'b0;
      end else if (thm_clr) begin
         long_wait_r <= safe_new;
      end else if (safe_new) begin
         long_wait_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Read answer
   // ----------------------------------------
   // Answer holds the word as it stood before any clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_r <= '0;
      end else begin
         rsp_r.valid <= req.valid;
         rsp_r.hit   <= sup_sel || thm_sel;
         rsp_r.data  <= sup_sel ? sup_r : (thm_sel ? thm_r : 16'h0000);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   chk_reserved_zero: assert property (
      sup_r[14:13] == 2'h0 && thm_r[15:4] == 12'h000
   ) else $error("reserved status bits not zero");

   chk_soft_por: assert property (
      soft_reset |=> !sup_r[`STSF_B_POR] && thm_r == 16'h0000
   ) else $error("soft reset left flags set");

   chk_por_hold: assert property (
      sup_r[`STSF_B_POR] && !sup_clr && !soft_reset |=> sup_r[`STSF_B_POR]
   ) else $error("power-on flag lost without clear");

   chk_word_clear: assert property (
      sup_clr && !soft_reset |=> sup_r == ($past(sup_set) & `STSF_SUP_MASK)
   ) else $error("supply word not cleared whole");

   chk_read_keeps: assert property (
      sup_sel && !req.clear && !soft_reset |=> (sup_r & $past(sup_r)) == $past(sup_r)
   ) else $error("read changed supply word");

   chk_read_data: assert property (
      thm_sel |=> rsp_r.valid && rsp_r.hit && rsp_r.data == $past(thm_r)
   ) else $error("thermal read data wrong");

   chk_bat_gate: assert property (
      $rose(sup_r[`STSF_B_BAT_UV]) |-> $past(ctx.reg_on)
   ) else $error("battery flag set with regulator off");

   chk_sleep_off: assert property (
      $rose(sup_r[`STSF_B_REG_SC]) |->
         !($past(ctx.mode) == stsf_pkg::STSF_SLEEP && !$past(ctx.reg_on))
   ) else $error("short flag set in sleep with regulator off");

   chk_uv_restart: assert property (
      $rose(sup_r[`STSF_B_REG_UV]) |->
         $past(ctx.mode) != stsf_pkg::STSF_RESTART || $past(sc_long)
   ) else $error("undervoltage flag updated in restart");

   chk_thm_sticky: assert property (
      thm_r[`STSF_B_MODULE_SHUTDOWN_FLAG] && !thm_clr && !soft_reset |=> thm_r[`STSF_B_MODULE_SHUTDOWN_FLAG]
   ) else $error("thermal flag dropped without clear");

   chk_long_wait: assert property (
      $rose(thm_r[`STSF_B_SAFE]) |-> long_wait_r
   ) else $error("long wait not selected with safe flag");

   chk_wait_clear: assert property (
      thm_clr && !soft_reset |=> long_wait_r == $past(safe_new)
   ) else $error("long wait not dropped by thermal clear");

   chk_pump_ot: assert property (
      det_q.pump_ot && !soft_reset |=> sup_r[`STSF_B_PUMP_OT]
   ) else $error("pump overtemperature flag not set");

   chk_prewarn_set: assert property (
      det_q.reg_prewarn && !soft_reset |=> sup_r[`STSF_B_REG_PW]
   ) else $error("regulator prewarning flag not set");

   chk_int_uv_stop: assert property (
      $rose(sup_r[`STSF_B_INT_UV]) |->
         $past(ctx.mode) != stsf_pkg::STSF_STOP || $past(det_q.load_peak) || $past(sup_r[`STSF_B_REG_PW])
   ) else $error("internal undervoltage flag set in stop mode");

   chk_module_off: assert property (
      det_q.module_shutdown_flag && !soft_reset |=> module_off_r && thm_r[`STSF_B_MODULE_SHUTDOWN_FLAG]
   ) else $error("first-level shutdown not applied");

   chk_tpw_set: assert property (
      det_q.thermal_prewarn_flag && !soft_reset |=> thm_r[`STSF_B_TPW]
   ) else $error("thermal prewarning flag not set");

endmodule

/* File: hdl/stsf_sat_cnt.sv */
// Saturating event counter with terminal flag
`timescale 1ns/1ps
module stsf_sat_cnt #(
   parameter int W   = 8,
   parameter int MAX = 4
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic clr,
   input  wire logic inc,
   output logic      hit
);
   logic [W-1:0] cnt_r;

   initial begin
      if (MAX < 1 || MAX >= (2 ** W)) $error("stsf_sat_cnt: MAX out of range");
   end

   // Clear wins; count holds once MAX is reached
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= '0;
      end else if (clr) begin
         cnt_r <= '0;
      end else if (inc && !hit) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign hit = (cnt_r == W'(MAX));
endmodule

/* File: hdl/stsf_sync.sv */
// Two-flop synchroniser for a group of detector levels
`timescale 1ns/1ps
module stsf_sync #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   initial begin
      if (W < 1) $error("stsf_sync: W must be positive");
   end

   // First stage feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

/* File: shared/stsf_defines.svh */
// Offsets, bit positions, reset values and timing of the status flag bank
`ifndef STSF_DEFINES_SVH
`define STSF_DEFINES_SVH

// ----------------------------------------
// Word addresses
// ----------------------------------------
`define STSF_SUP_ADDR   7'h40
`define STSF_THM_ADDR   7'h41

// ----------------------------------------
// Supply word bits
// ----------------------------------------
`define STSF_B_POR      15
`define STSF_B_PUMP_OT  12
`define STSF_B_UV_FS    11
`define STSF_B_SW_UV    10
`define STSF_B_SW_OV    9
`define STSF_B_INT_UV   8
`define STSF_B_INT_OV   7
`define STSF_B_BAT_UV   6
`define STSF_B_BAT_OV   5
`define STSF_B_PUMP_UV  4
`define STSF_B_REG_SC   3
`define STSF_B_REG_UV   2
`define STSF_B_REG_OV   1
`define STSF_B_REG_PW   0

// ----------------------------------------
// Thermal word bits
// ----------------------------------------
`define STSF_B_SAFE     3
`define STSF_B_SEVERE_SHUTDOWN_FLAG     2
`define STSF_B_MODULE_SHUTDOWN_FLAG     1
`define STSF_B_TPW      0

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define STSF_POR_RST    16'h8000
`define STSF_SOFT_RST   16'h0000
`define STSF_THM_RST    16'h0000
`define STSF_SUP_MASK   16'h9FFF
`define STSF_THM_MASK   16'h000F

// ----------------------------------------
// Timing and counts
// ----------------------------------------
`define STSF_CLK_MHZ    100
`define STSF_SC_UV_US   2000
`define STSF_UV_FS_CNT  4
`define STSF_SEVERE_SHUTDOWN_FLAG_CNT   16
`define STSF_WAIT_S     64

`endif

/* File: shared/stsf_pkg.sv */
// Types shared by the status flag bank
package stsf_pkg;

   // ----------------------------------------
   // Device operating modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      STSF_INIT     = 3'h0,
      STSF_NORMAL   = 3'h1,
      STSF_STOP     = 3'h3,
      STSF_SLEEP    = 3'h2,
      STSF_RESTART  = 3'h6,
      STSF_FAILSAFE = 3'h7
   } stsf_mode_e;

   // ----------------------------------------
   // Decoded frame and answer
   // ----------------------------------------
   typedef struct packed {
      logic       valid;
      logic       clear;
      logic [6:0] addr;
   } stsf_req_s;

   typedef struct packed {
      logic        valid;
      logic        hit;
      logic [15:0] data;
   } stsf_rsp_s;

   // ----------------------------------------
   // Mode context from the state machine
   // ----------------------------------------
   typedef struct packed {
      stsf_mode_e mode;
      logic       reg_on;
      logic       rst_released;
   } stsf_ctx_s;

   // ----------------------------------------
   // Analog detector levels
   // ----------------------------------------
   typedef struct packed {
      logic pump_ot;
      logic sw_uv;
      logic sw_ov;
      logic int_uv;
      logic int_ov;
      logic bat_uv;
      logic bat_ov;
      logic pump_uv;
      logic reg_short;
      logic reg_uv;
      logic reg_ov;
      logic reg_prewarn;
      logic load_peak;
      logic severe_shutdown_flag;
      logic module_shutdown_flag;
      logic thermal_prewarn_flag;
   } stsf_det_s;

endpackage

/* File: test/stsf_host_model.sv */
// Host master model issuing read and read-and-clear word frames
`timescale 1ns/1ps
module stsf_host_model (
   input  wire logic                clk,
   output stsf_pkg::stsf_req_s      req,
   input  wire stsf_pkg::stsf_rsp_s rsp_r
);
   // ----------------------------------------
   // Idle state
   // ----------------------------------------
   initial begin
      req = '0;
   end

   // ----------------------------------------
   // One frame, answer taken one edge later, then one idle edge
   // ----------------------------------------
   // Idle fields carry the inverse of the last frame, so a stale value is never mistaken for a live one
   task automatic xfer(input  logic        clr,
                       input  logic [6:0]  addr,
                       output logic [15:0] data,
                       output logic        hit,
                       output logic        vld);
      req.valid = 1'b1;
      req.clear = clr;
      req.addr  = addr;
      @(posedge clk);
      #1;
      vld       = rsp_r.valid;
      hit       = rsp_r.hit;
      data      = rsp_r.data;
      req.valid = 1'b0;
      req.clear = ~clr;
      req.addr  = ~addr;
      @(posedge clk);
      #1;
   endtask
endmodule

/* File: test/test_supply_thermal_status_flags.sv */
// Self-checking testbench for the supply and thermal status flag bank
`timescale 1ns/1ps
`include "stsf_defines.svh"
module test_supply_thermal_status_flags;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam logic [6:0] SUP = `STSF_SUP_ADDR;
   localparam logic [6:0] THM = `STSF_THM_ADDR;
   logic                clk            = 1'b0;
   logic                reset_n        = 1'b0;
   logic                soft_reset     = 1'b0;
   stsf_pkg::stsf_req_s req;
   stsf_pkg::stsf_ctx_s ctx;
   stsf_pkg::stsf_det_s det;
   stsf_pkg::stsf_rsp_s rsp_r;
   logic                failsafe_req_r;
   logic                module_off_r;
   logic                long_wait_r;
   int                  n_fail         = 0;
   int                  comparisons    = 0;
   int                  n_fs           = 0;

   always #5 clk = ~clk;

   // Short count keeps the long-undervoltage case brief
   stsf_flags #(.SC_UV_CYC(20)) stsf_flags_i (
      .clk           (clk),
      .reset_n       (reset_n),
      .soft_reset    (soft_reset),
      .req           (req),
      .ctx           (ctx),
      .det           (det),
      .rsp_r         (rsp_r),
      .failsafe_req_r(failsafe_req_r),
      .module_off_r  (module_off_r),
      .long_wait_r   (long_wait_r)
   );

   stsf_host_model stsf_host_model_i (
      .clk  (clk),
      .req  (req),
      .rsp_r(rsp_r)
   );

   always @(posedge clk) begin
      if (failsafe_req_r === 1'b1) begin
         n_fs++;
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic cmp16(input string what, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cmp1(input string what, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic access(input logic c, input logic [6:0] a, input logic [15:0] e);
      logic [15:0] d;
      logic        h;
      logic        v;
      stsf_host_model_i.xfer(c, a, d, h, v);
      cmp1("valid", 1'b1, v);
      cmp1("hit", (a == SUP) || (a == THM), h);
      cmp16("word", e, d);
   endtask

   // Rise, hold, drop, then let the sync and flag stages settle
   task automatic pulse(input int i, input int hold);
      det[i] = 1'b1;
      cyc(hold);
      det[i] = 1'b0;
      cyc(4);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      access(1'b0, SUP, 16'h8000);
      access(1'b0, SUP, 16'h8000);
      access(1'b0, THM, 16'h0000);
      access(1'b1, SUP, 16'h8000);
      access(1'b0, SUP, 16'h0000);
   endtask

   task automatic t_bits();
      int          di [15] = '{15, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 2, 1, 0};
      logic [15:0] ex [15] = '{16'h1000, 16'h0400, 16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0020,
                               16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0001, 16'h0004, 16'h0002, 16'h0001};
      for (int i = 0; i < 15; i++) begin
         pulse(di[i], 2);
         access(1'b0, (i < 12) ? SUP : THM, ex[i]);
         access(1'b1, (i < 12) ? SUP : THM, ex[i]);
         access(1'b0, (i < 12) ? SUP : THM, 16'h0000);
      end
   endtask

   task automatic t_gate();
      ctx.reg_on = 1'b0;
      pulse(10, 2);
      access(1'b1, SUP, 16'h0000);
      ctx.reg_on = 1'b1;
      ctx.mode   = stsf_pkg::STSF_STOP;
      pulse(12, 2);
      access(1'b1, SUP, 16'h0000);
      det.load_peak = 1'b1;
      pulse(12, 2);
      det.load_peak = 1'b0;
      access(1'b1, SUP, 16'h0100);
      pulse(4, 2);
      pulse(12, 2);
      access(1'b1, SUP, 16'h0101);
      ctx.mode   = stsf_pkg::STSF_SLEEP;
      ctx.reg_on = 1'b0;
      det.reg_short = 1'b1;
      det.reg_ov    = 1'b1;
      pulse(6, 2);
      det.reg_short = 1'b0;
      det.reg_ov    = 1'b0;
      cyc(4);
      access(1'b1, SUP, 16'h0000);
      ctx.reg_on = 1'b1;
      ctx.mode   = stsf_pkg::STSF_RESTART;
      pulse(6, 2);
      access(1'b1, SUP, 16'h0000);
      ctx.mode         = stsf_pkg::STSF_INIT;
      ctx.rst_released = 1'b0;
      pulse(6, 2);
      access(1'b1, SUP, 16'h0000);
      ctx.rst_released = 1'b1;
      pulse(6, 2);
      access(1'b1, SUP, 16'h0004);
      ctx.mode = stsf_pkg::STSF_RESTART;
      pulse(6, 30);
      access(1'b1, SUP, 16'h0004);
      ctx.mode = stsf_pkg::STSF_NORMAL;
   endtask

   task automatic t_failsafe();
      int base;
      base = n_fs;
      repeat (3) pulse(6, 2);
      access(1'b0, SUP, 16'h0004);
      pulse(6, 2);
      access(1'b1, SUP, 16'h0804);
      cmp16("uv failsafe pulses", 16'h0001, 16'(n_fs - base));
      access(1'b0, SUP, 16'h0000);
   endtask

   task automatic t_severe();
      int base;
      base = n_fs;
      repeat (16) pulse(2, 2);
      access(1'b0, THM, 16'h0004);
      cmp1("long wait", 1'b0, long_wait_r);
      pulse(2, 2);
      access(1'b0, THM, 16'h000C);
      cmp1("long wait", 1'b1, long_wait_r);
      cmp16("severe pulses", 16'h0011, 16'(n_fs - base));
      access(1'b1, THM, 16'h000C);
      cyc(2);
      cmp1("long wait", 1'b0, long_wait_r);
      det.module_shutdown_flag = 1'b1;
      cyc(5);
      cmp1("module off", 1'b1, module_off_r);
      det.module_shutdown_flag = 1'b0;
      cyc(5);
      cmp1("module off", 1'b0, module_off_r);
      access(1'b1, THM, 16'h0002);
   endtask

   task automatic t_soft();
      pulse(15, 2);
      pulse(0, 2);
      access(1'b1, 7'h42, 16'h0000);
      access(1'b0, SUP, 16'h1000);
      access(1'b1, THM, 16'h0001);
      access(1'b0, SUP, 16'h1000);
      pulse(1, 2);
      soft_reset = 1'b1;
      cyc(1);
      soft_reset = 1'b0;
      cyc(1);
      access(1'b0, SUP, 16'h0000);
      access(1'b0, THM, 16'h0000);
      reset_n = 1'b0;
      cyc(2);
      reset_n = 1'b1;
      cyc(1);
      access(1'b0, SUP, 16'h8000);
   endtask

   // ----------------------------------------
   // Verdict
   // ----------------------------------------
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   initial begin
      #200us;
      n_fail++;
      conclude();
   end

   initial begin
      det              = '0;
      ctx.mode         = stsf_pkg::STSF_NORMAL;
      ctx.reg_on       = 1'b1;
      ctx.rst_released = 1'b1;
      cyc(12);
      reset_n = 1'b1;
      cyc(1);
      t_reset();
      t_bits();
      t_gate();
      t_failsafe();
      t_severe();
      t_soft();
      conclude();
   end
endmodule
